// File: core/tfp_pkg.sv
// Package: constants and types for the thermal fan drive controller
package tfp_pkg;

  // ****************************************************************
  // Timebase
  // ****************************************************************
  localparam int unsigned CLK_HZ = 50_000_000;  // System clock rate
  localparam int unsigned PWM_HZ = 30;          // Nominal ramp rate
  // Control code width; one ramp period is 2^CODE_W steps
  localparam int CODE_W = 8;
  localparam int unsigned RAMP_STEPS = 256;
  // Clocks per ramp step, rounded down so the period never runs long
  localparam int unsigned STEP_CYC = CLK_HZ / (PWM_HZ * RAMP_STEPS);
  localparam int PRE_W = 13;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYC - 1);
  localparam logic [CODE_W-1:0] RAMP_LAST = 8'hFF;
  localparam logic [CODE_W-1:0] CODE_FULL = 8'hFF;  // Code for full duty

  // ****************************************************************
  // Start-up burst
  // ****************************************************************
  localparam int BURST_W = 6;
  localparam logic [BURST_W-1:0] BURST_PERIODS = 6'h20;  // 32 periods

  // ****************************************************************
  // Input synchroniser and reset values
  // ****************************************************************
  localparam int SYNC_BITS = 4;   // halt, release, below-as, above-as+hys
  localparam int SYNC_W = 12;     // Code plus the four condition bits
  localparam logic [SYNC_W-1:0] SYNC_RST = 12'h000;

  // Controller modes, one-hot
  typedef enum logic [3:0] {
    TFP_HALT  = 4'h1,  // Held in shutdown / reset
    TFP_AUTO  = 4'h2,  // Auto-shutdown, fan off
    TFP_BURST = 4'h4,  // Full-on spin-up
    TFP_RUN   = 4'h8   // Proportional drive
  } tfp_mode_t;

endpackage

// File: core/tfp_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
`default_nettype none
module tfp_sync
  import tfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Raw pin levels
  input wire logic [SYNC_W-1:0] pin_in,
  // Settled levels
  output logic [SYNC_W-1:0] pin_out
);

  // ****************************************************************
  // Per-bit chain
  // ****************************************************************
  logic [SYNC_W-1:0] s2_v;  // Stage two of every bit
  logic [SYNC_W-1:0] s3_v;  // Stage three of every bit
  logic code_agree;         // Whole code word steady across stages

  // The code is a word: accept it only when every bit agrees, so a
  // half-changed code never reaches the duty latch
  assign code_agree = (s2_v[SYNC_W-1:SYNC_BITS] == s3_v[SYNC_W-1:SYNC_BITS]);

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_bit
      logic s1_r;  // Metastable stage, read only by s2
      logic s2_r;
      logic s3_r;
      logic q_r;   // Accepted level
      // Code bits wait for the whole word, condition bits for themselves
      localparam bit IS_CODE = (gi >= SYNC_BITS);
      // Shift chain; a change counts once stages two and three agree
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          q_r <= 1'b0;
        end
        else
        begin
          s1_r <= pin_in[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (IS_CODE ? code_agree : (s2_r == s3_r))
          begin
            q_r <= s3_r;
          end
        end
      end
      assign pin_out[gi] = q_r;
      assign s2_v[gi] = s2_r;
      assign s3_v[gi] = s3_r;
    end
  endgenerate

endmodule
`default_nettype wire

// File: core/tfp_ctrl.sv
// Thermal fan drive controller: modes, spin-up burst and PWM drive
//
// Contract
// - duty tracks code, low zero, high full
// - ramp period set near 30 Hz
// - burst timer counts whole ramp periods
// - drive fully on for 32 periods
// - burst on warm release from halt and on auto-off exit
// - after burst, proportional until shutdown entered
// - below auto threshold, enter auto-off, drive off
// - leave auto-off only above hysteresis, burst
// - flag low while above full level, unlatched
// - halt level stops all, flag inactive
// - entering halt resets all state
// - above release leaves halt, burst if warm
// - still cold at release, go auto-off
// - drive pin active high
// - code resampled every ramp period
// - on shutdown, duty zero, flag off
`timescale 1ns/100ps
`default_nettype none
module tfp_ctrl
  import tfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Quantised control level and comparator results
  input wire logic [CODE_W-1:0] temp_control_input,
  input wire logic halt_level,
  input wire logic release_level,
  input wire logic below_autoshutdown,
  input wire logic above_autoshutdown_hysteresis,
  input wire logic overtemp_level,
  // Outputs to the fan switch and the system
  output logic fan_drive_pin,
  output logic overtemp_flag_n,
  output logic [3:0] mode_state
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [SYNC_W-1:0] raw_pins;  // Pins gathered for the chain
  logic [SYNC_W-1:0] sync_pins; // Settled copies
  logic [CODE_W-1:0] code_s;    // Settled control code
  logic halt_s;
  logic rel_s;
  logic below_s;
  logic above_s;
  logic ot_r1;                  // Overtemp chain kept apart, see below
  logic ot_r2;
  logic ot_r3;
  logic ot_s;

  assign raw_pins = {temp_control_input, halt_level, release_level,
                     below_autoshutdown, above_autoshutdown_hysteresis};

  // Comparator bits and code all pass three flops
  tfp_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(raw_pins),
    .pin_out(sync_pins)
  );

  assign code_s = sync_pins[SYNC_W-1:SYNC_BITS];
  assign halt_s = sync_pins[3];
  assign rel_s = sync_pins[2];
  assign below_s = sync_pins[1];
  assign above_s = sync_pins[0];

  // Overtemp comparator synchroniser with agreement filter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ot_r1 <= 1'b0;
      ot_r2 <= 1'b0;
      ot_r3 <= 1'b0;
      ot_s <= 1'b0;
    end
    else
    begin
      ot_r1 <= overtemp_level;
      ot_r2 <= ot_r1;
      ot_r3 <= ot_r2;
      if (ot_r2 == ot_r3)
      begin
        ot_s <= ot_r3;
      end
    end
  end

  // ****************************************************************
  // Ramp timebase
  // ****************************************************************
  logic [PRE_W-1:0] pre_r;   // Clocks within one ramp step
  logic [CODE_W-1:0] ramp_r; // Ramp position within the period
  logic step_end;
  logic period_end;          // Last clock of a ramp period

  assign step_end = (pre_r == PRE_LAST);
  assign period_end = step_end && (ramp_r == RAMP_LAST);

  // Free-running ramp, roughly 30 Hz, held at zero while halted
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_r <= '0;
      ramp_r <= '0;
    end
    else if (halt_s)
    begin
      // All functions stop in halt
      pre_r <= '0;
      ramp_r <= '0;
    end
    else if (step_end)
    begin
      pre_r <= '0;
      ramp_r <= ramp_r + 8'h01;
    end
    else
    begin
      pre_r <= pre_r + 13'h0001;
    end
  end

  // ****************************************************************
  // Mode machine
  // ****************************************************************
  tfp_mode_t mode_r;
  tfp_mode_t mode_nxt;
  logic [BURST_W-1:0] burst_r;  // Whole periods spent in burst
  logic burst_done;

  assign burst_done = period_end && (burst_r == BURST_PERIODS - 6'h01);

  // Next mode; halt wins over every other condition
  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      TFP_HALT:
      begin
        // Release: burst when warm, else auto-off
        if (!halt_s && rel_s)
        begin
          mode_nxt = above_s ? TFP_BURST : TFP_AUTO;
        end
      end
      TFP_AUTO:
      begin
        // Leave only past threshold plus hysteresis
        if (halt_s)
          mode_nxt = TFP_HALT;
        else if (above_s)
          mode_nxt = TFP_BURST;
      end
      TFP_BURST:
      begin
        // Halt aborts the burst at once
        if (halt_s)
          mode_nxt = TFP_HALT;
        else if (below_s)
          mode_nxt = TFP_AUTO;
        else if (burst_done)
          mode_nxt = TFP_RUN;
      end
      TFP_RUN:
      begin
        if (halt_s)
          mode_nxt = TFP_HALT;
        else if (below_s)
          mode_nxt = TFP_AUTO;
      end
      default:
      begin
        mode_nxt = TFP_HALT;
      end
    endcase
  end

  // Mode register; reset is the halted power-up state
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= TFP_HALT;
    else
      mode_r <= mode_nxt;
  end

  // Burst period counter, cleared on every entry
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      burst_r <= '0;
    else if (mode_r != TFP_BURST)
      burst_r <= '0;
    else if (period_end)
      burst_r <= burst_r + 6'h01;  // Whole periods only
  end

  // ****************************************************************
  // Duty code latch and outputs
  // ****************************************************************
  logic [CODE_W-1:0] duty_r;  // Code held for the current period

  // Resample at each period start so the duty is glitch-free
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      duty_r <= '0;
    else if (mode_r == TFP_HALT)
      duty_r <= '0;
    else if (period_end || mode_r != TFP_RUN)
      duty_r <= code_s;
  end

  // Drive: full in burst, compare in run, off otherwise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fan_drive_pin <= 1'b0;
    else if (mode_nxt == TFP_BURST)
      fan_drive_pin <= 1'b1;  // High turns the switch on
    else if (mode_nxt == TFP_RUN)
      // Full code stays on across the whole period
      fan_drive_pin <= (duty_r == CODE_FULL) || (ramp_r < duty_r);
    else
      fan_drive_pin <= 1'b0;
  end

  // Unlatched overtemp flag, gated off outside active modes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      overtemp_flag_n <= 1'b1;
    else if (mode_nxt == TFP_RUN || mode_nxt == TFP_BURST)
      overtemp_flag_n <= !ot_s;
    else
      overtemp_flag_n <= 1'b1;
  end

  // Mode visible for debug
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mode_state <= 4'h1;
    else
      mode_state <= mode_nxt;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_halt_drive_off: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_r == TFP_HALT) |-> !fan_drive_pin && overtemp_flag_n)
    else $error("drive or flag active in halt");

  a_burst_full_on: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_r == TFP_BURST) |-> fan_drive_pin)
    else $error("drive low during burst");

  a_burst_length: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_r == TFP_RUN) |-> $past(mode_r) == TFP_RUN || burst_r == BURST_PERIODS)
    else $error("run entered before 32 periods");

  a_auto_off: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_r == TFP_AUTO) |-> !fan_drive_pin && overtemp_flag_n)
    else $error("drive active in auto-off");

  a_halt_enter: assert property (@(posedge clock) disable iff (!rst_n)
    halt_s |=> mode_r == TFP_HALT)
    else $error("halt not entered");

  a_auto_exit: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_r == TFP_AUTO && !halt_s && above_s) |=> mode_r == TFP_BURST)
    else $error("auto-off exit missed burst");

  a_release_cold: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_r == TFP_HALT && !halt_s && rel_s && !above_s) |=> mode_r == TFP_AUTO)
    else $error("cold release did not go auto-off");

  a_run_compare: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_r == TFP_RUN && mode_nxt == TFP_RUN && duty_r == 8'h00) |=> !fan_drive_pin)
    else $error("zero code drove fan");

  a_flag_follow: assert property (@(posedge clock) disable iff (!rst_n)
    ((mode_nxt == TFP_RUN || mode_nxt == TFP_BURST) && ot_s) |=> !overtemp_flag_n)
    else $error("overtemp flag not asserted");

  c_burst_done: cover property (@(posedge clock) disable iff (!rst_n)
    mode_r == TFP_BURST ##1 mode_r == TFP_RUN);
  c_auto_entry: cover property (@(posedge clock) disable iff (!rst_n)
    mode_r == TFP_RUN ##1 mode_r == TFP_AUTO);
  c_burst_abort: cover property (@(posedge clock) disable iff (!rst_n)
    mode_r == TFP_BURST ##1 mode_r == TFP_HALT);
  c_flag_low: cover property (@(posedge clock) disable iff (!rst_n)
    !overtemp_flag_n);

endmodule
`default_nettype wire

// File: testbench/tfp_sensor_model.sv
// Partner model: sensor divider, threshold comparators and the fan switch
`timescale 1ns/100ps
`default_nettype none
module tfp_sensor_model
  import tfp_pkg::*;
#(
  parameter int HALT_MV = 650,   // Shutdown level
  parameter int REL_MV = 950,    // Release level
  parameter int AS_MV = 1600,    // Auto-off threshold from the divider
  parameter int HAS_MV = 70,     // Auto-off hysteresis
  parameter int LOW_MV = 1250,   // Zero duty level
  parameter int FULL_MV = 2650   // Full duty and overtemp level
)
(
  // Sensor voltage from the bench, millivolts
  input wire logic [11:0] vin_mv,
  // Gate drive from the controller
  input wire logic fan_drive_pin,
  // Condition bits and code towards the controller
  output logic [CODE_W-1:0] code,
  output logic halt_cmp,
  output logic rel_cmp,
  output logic below_cmp,
  output logic above_cmp,
  output logic ot_cmp,
  // Fan state seen by the system
  output logic fan_on
);
  // ****************************************************************
  // Comparators
  // ****************************************************************
  // Threshold is never grounded here, so auto-off stays reachable
  always_comb
  begin
    halt_cmp = (int'(vin_mv) < HALT_MV);
    rel_cmp = (int'(vin_mv) > REL_MV);
    below_cmp = (int'(vin_mv) < AS_MV);
    above_cmp = (int'(vin_mv) > AS_MV + HAS_MV);
    ot_cmp = (int'(vin_mv) > FULL_MV);
  end

  // Linear span quantised to the code; clipped at both ends
  always_comb
  begin
    if (int'(vin_mv) <= LOW_MV)
      code = 8'h00;
    else if (int'(vin_mv) >= FULL_MV)
      code = 8'hFF;
    else
      code = CODE_W'(((int'(vin_mv) - LOW_MV) * 255) / (FULL_MV - LOW_MV));
  end

  // Low-side switch conducts on a high gate
  assign fan_on = (fan_drive_pin === 1'b1);
endmodule
`default_nettype wire

// File: testbench/thermal_fan_pwm_controller_tb.sv
// Testbench for the thermal fan drive controller
`timescale 1ns/100ps
`default_nettype none
module thermal_fan_pwm_controller_tb;
  import tfp_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] vin_mv = 12'h12C;  // Start held in shutdown (300 mV)
  logic [CODE_W-1:0] code;
  logic halt_cmp, rel_cmp, below_cmp, above_cmp, ot_cmp, fan_on;
  logic fan_drive_pin, overtemp_flag_n;
  logic [3:0] mode_state;
  int fails = 0;
  int checks_done = 0;

  // 50 MHz clock
  always #10 clock = ~clock;

  // ****************************************************************
  // Instances
  // ****************************************************************
  tfp_sensor_model i_tfp_sensor_model (.vin_mv(vin_mv), .fan_drive_pin(fan_drive_pin), .code(code),
    .halt_cmp(halt_cmp), .rel_cmp(rel_cmp), .below_cmp(below_cmp), .above_cmp(above_cmp),
    .ot_cmp(ot_cmp), .fan_on(fan_on));
  tfp_ctrl i_tfp_ctrl (.clock(clock), .rst_n(rst_n), .temp_control_input(code), .halt_level(halt_cmp),
    .release_level(rel_cmp), .below_autoshutdown(below_cmp), .above_autoshutdown_hysteresis(above_cmp),
    .overtemp_level(ot_cmp), .fan_drive_pin(fan_drive_pin), .overtemp_flag_n(overtemp_flag_n),
    .mode_state(mode_state));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_sim();
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Selects mode, flag or drive as a 4-bit value
  function automatic logic [3:0] probe(input int sel);
    if (sel == 0)
      return mode_state;
    else if (sel == 1)
      return {3'h0, overtemp_flag_n};
    return {3'h0, fan_drive_pin};
  endfunction

  // New sensor level, launched on a rising edge
  task automatic set_v(input logic [11:0] v);
    @(posedge clock);
    vin_mv <= v;
  endtask

  // Bounded wait; synchroniser plus one edge fits well inside 12
  task automatic wait_eq(input string what, input int sel, input logic [3:0] exp);
    int n;
    n = 0;
    @(negedge clock);
    while (probe(sel) !== exp && n < 12)
    begin
      @(negedge clock);
      n++;
    end
    chk(what, exp, probe(sel));
  endtask

  // Mode, drive and flag all held for n cycles
  task automatic hold(input logic [3:0] m, input logic f, input logic ot_n, input int n);
    repeat (n)
    begin
      @(negedge clock);
      chk("mode_state", m, mode_state);
      chk("fan_drive_pin", {3'h0, f}, {3'h0, fan_drive_pin});
      chk("fan_on", {3'h0, f}, {3'h0, fan_on});
      chk("overtemp_flag_n", {3'h0, ot_n}, {3'h0, overtemp_flag_n});
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset and held shutdown: drive off, flag idle
  task automatic t_halt_hold();
    hold(4'h1, 1'b0, 1'b1, 30);
  endtask

  // Release while cold lands in auto-off, no spin-up
  task automatic t_release_cold();
    set_v(12'h578);                                   // 1400 mV
    wait_eq("mode_state", 0, 4'h2);
    hold(4'h2, 1'b0, 1'b1, 20);
  endtask

  // Inside the hysteresis band nothing restarts; above it the burst runs full on
  task automatic t_auto_exit();
    set_v(12'h672);                                   // 1650 mV
    hold(4'h2, 1'b0, 1'b1, 20);
    set_v(12'h6A4);                                   // 1700 mV
    wait_eq("mode_state", 0, 4'h4);
    hold(4'h4, 1'b1, 1'b1, 2000);
  endtask

  // Flag follows the overtemp level both ways without latching
  task automatic t_overtemp();
    set_v(12'hAF0);                                   // 2800 mV
    wait_eq("overtemp_flag_n", 1, 4'h0);
    set_v(12'hA28);                                   // 2600 mV
    wait_eq("overtemp_flag_n", 1, 4'h1);
  endtask

  // Cooling under the threshold drops to auto-off
  task automatic t_to_auto();
    set_v(12'hAF0);
    wait_eq("overtemp_flag_n", 1, 4'h0);
    set_v(12'h5DC);                                   // 1500 mV
    wait_eq("mode_state", 0, 4'h2);
    hold(4'h2, 1'b0, 1'b1, 10);
  endtask

  // Shutdown aborts a burst; warm release restarts it from scratch
  task automatic t_halt_abort();
    set_v(12'h6A4);
    wait_eq("mode_state", 0, 4'h4);
    set_v(12'h12C);                                   // 300 mV
    wait_eq("mode_state", 0, 4'h1);
    hold(4'h1, 1'b0, 1'b1, 20);
    set_v(12'h6A4);                                   // Warm at release
    wait_eq("mode_state", 0, 4'h4);
    hold(4'h4, 1'b1, 1'b1, 500);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_halt_hold();
    t_release_cold();
    t_auto_exit();
    t_overtemp();
    t_to_auto();
    t_halt_abort();
    end_sim();
  end

  // Tests take about 3000 cycles; allow ample margin
  initial
  begin
    repeat (50000) @(posedge clock);
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
